// [hdl/dmc_pkg.sv]
package dmc_pkg;
	// Register indexes; byte address is four times the index
	localparam logic [2:0]  REG_STATUS_IDX     = 3'h0;
	localparam logic [2:0]  REG_RD_ADDR_IDX    = 3'h1;
	localparam logic [2:0]  REG_WR_ADDR_IDX    = 3'h2;
	localparam logic [2:0]  REG_LENGTH_IDX     = 3'h3;
	localparam logic [2:0]  REG_CONTROL_IDX    = 3'h6;
	// Status bit positions
	localparam int          ST_DONE            = 0;
	localparam int          ST_BUSY            = 1;
	localparam int          ST_RD_PKT_END      = 2;
	localparam int          ST_WR_PKT_END      = 3;
	localparam int          ST_COUNT_ZERO      = 4;
	// Control bit positions
	localparam int          CT_BYTE            = 0;
	localparam int          CT_HALFWORD        = 1;
	localparam int          CT_WORD            = 2;
	localparam int          CT_RUN             = 3;
	localparam int          CT_IRQ_EN          = 4;
	localparam int          CT_STOP_RD_EOP     = 5;
	localparam int          CT_STOP_WR_EOP     = 6;
	localparam int          CT_STOP_COUNT      = 7;
	localparam int          CT_FIX_RD          = 8;
	localparam int          CT_FIX_WR          = 9;
	localparam int          CT_DOUBLEWORD      = 10;
	localparam int          CT_QUADWORD        = 11;
	localparam int          CT_ENGINE_RESET    = 12;
	localparam int          CT_WIDTH           = 13;
	// Reset values
	localparam logic [12:0] CONTROL_RESET      = 13'h0000;
	// Bytes per beat for each size
	localparam logic [4:0]  BYTES_BYTE         = 5'h01;
	localparam logic [4:0]  BYTES_HALFWORD     = 5'h02;
	localparam logic [4:0]  BYTES_WORD         = 5'h04;
	localparam logic [4:0]  BYTES_DOUBLEWORD   = 5'h08;
	localparam logic [4:0]  BYTES_QUADWORD     = 5'h10;
	// Internal reset pulse length in cycles
	localparam logic [1:0]  SRST_HOLD_CYCLES   = 2'h2;
	// Engine states, Gray coded along idle-read-write
	typedef enum logic [1:0] {
		DMC_IDLE  = 2'b00,
		DMC_READ  = 2'b01,
		DMC_WRITE = 2'b11
	} dmc_state_t;
endpackage

// [hdl/dmc_beat_size.sv]
`timescale 1ns/100ps
// Turns one-hot size select into a byte count per beat
module dmc_beat_size (
	input  wire logic [4:0] size_sel,
	output logic      [4:0] beat_bytes
);
	// Priority order is arbitrary; several bits set is undefined anyway
	always_comb begin
		if (size_sel[4]) begin
			beat_bytes = dmc_pkg::BYTES_QUADWORD;
		end else if (size_sel[3]) begin
			beat_bytes = dmc_pkg::BYTES_DOUBLEWORD;
		end else if (size_sel[2]) begin
			beat_bytes = dmc_pkg::BYTES_WORD;
		end else if (size_sel[1]) begin
			beat_bytes = dmc_pkg::BYTES_HALFWORD;
		end else begin
			beat_bytes = dmc_pkg::BYTES_BYTE;
		end
	end
endmodule

// [hdl/dmc_soft_reset.sv]
`timescale 1ns/100ps
// Two writes of the trigger bit give an internal reset pulse
module dmc_soft_reset (
	input  wire logic ref_clk,
	input  wire logic rst_b,
	input  wire logic trig_write,
	output logic      armed,
	output logic      engine_rst
);
	logic       armed_r;     // First write seen
	logic [1:0] hold_r;      // Remaining pulse cycles

	// Sequencer is not cleared by its own pulse, so it always finishes
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			armed_r <= 1'b0;
			hold_r  <= 2'h0;
		end else if (hold_r != 2'h0) begin
			hold_r <= hold_r - 2'h1;
		end else if (trig_write && armed_r) begin
			armed_r <= 1'b0;
			hold_r  <= dmc_pkg::SRST_HOLD_CYCLES;
		end else if (trig_write) begin
			armed_r <= 1'b1;
		end
	end

	assign armed      = armed_r;
	assign engine_rst = (hold_r != 2'h0);
endmodule

// [hdl/dmc_engine.sv]
// The strobed register port and the address map were decided locally.
`timescale 1ns/100ps
// Operation
// - Five one-hot bits select transfer size
// - Run bit plus nonzero length starts
// - Run cleared early: completion never set
// - Interrupt equals completion and enable
// - Bit 5 lets read packet end stop
// - Bit 6 lets write packet end stop
// - Bit 7 lets zero count stop
// - Bit 8 holds read address fixed
// - Bit 9 holds write address fixed
// - Two trigger writes reset the engine
// - Status write clears completion unless it is set that cycle
// - Cause flags stay readable after completion
// - Status bit layout; zero write clears
// - Completion set on packet end or count
// - Count falls per write, stops at zero
// - Busy high during whole transaction
module dmc_engine #(
	parameter int ADDR_W = 32,
	parameter int LEN_W  = 32,
	parameter int DATA_W = 128
) (
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	// Register port
	input  wire logic [2:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	// Read master
	output logic                   rd_req,
	output logic      [ADDR_W-1:0] rd_addr,
	input  wire logic              rd_ack,
	input  wire logic [DATA_W-1:0] rd_data,
	input  wire logic              rd_eop,
	// Write master
	output logic                   wr_req,
	output logic      [ADDR_W-1:0] wr_addr,
	output logic      [DATA_W-1:0] wr_data,
	input  wire logic              wr_ack,
	input  wire logic              wr_eop,
	// Interrupt
	output logic                   irq
);
	logic [12:0]           ctrl_r;        // Control bits
	logic [ADDR_W-1:0]     rd_addr_r;     // Current read address
	logic [ADDR_W-1:0]     wr_addr_r;     // Current write address
	logic [LEN_W-1:0]      len_r;         // Remaining bytes
	logic [DATA_W-1:0]     data_r;        // Beat held between read and write
	logic                  done_r;        // Completion flag
	logic                  rd_pkt_r;      // Read packet end flag
	logic                  wr_pkt_r;      // Write packet end flag
	logic                  cnt_zero_r;    // Count expired flag
	logic                  eop_hold_r;    // Read eop latched for this beat
	logic [31:0]           rdata_r;       // Read data register
	dmc_pkg::dmc_state_t   state_r;       // Engine state
	dmc_pkg::dmc_state_t   state_nxt;
	logic [4:0]            beat_bytes;    // Bytes per beat
	logic                  arm_seen;      // First trigger write seen
	logic                  eng_rst;       // Internal reset pulse
	logic                  busy;          // Transaction in progress
	logic                  wr_beat;       // Write accepted this cycle
	logic                  rd_beat;       // Read accepted this cycle
	logic                  end_rd_pkt;    // Read eop ends transaction
	logic                  end_wr_pkt;    // Write eop ends transaction
	logic                  end_count;     // Zero count ends transaction
	logic                  finish;        // Transaction ends this beat
	logic [LEN_W-1:0]      len_after;     // Length after this beat
	logic                  sel_status;    // Register decodes
	logic                  sel_ctrl;
	logic                  sel_rdaddr;
	logic                  sel_wraddr;
	logic                  sel_len;
	logic                  trig_write;    // First or second reset write

	// Limitations a driver must respect:
	// - one size bit at a time; with several set the widest one wins
	// - run left set with length remaining restarts the engine at once
	// - the engine reset drops requests with no handshake, so an agent
	//   holding its bus may stall until the next system reset
	// - length is not checked against the size; a short tail floors at zero

	// Register decode; unmapped indexes match nothing and read as zero
	assign sel_status = (reg_addr == dmc_pkg::REG_STATUS_IDX);
	assign sel_ctrl   = (reg_addr == dmc_pkg::REG_CONTROL_IDX);
	assign sel_rdaddr = (reg_addr == dmc_pkg::REG_RD_ADDR_IDX);
	assign sel_wraddr = (reg_addr == dmc_pkg::REG_WR_ADDR_IDX);
	assign sel_len    = (reg_addr == dmc_pkg::REG_LENGTH_IDX);
	assign trig_write = reg_wr && sel_ctrl && reg_wdata[dmc_pkg::CT_ENGINE_RESET];

	// Reset sequencer, not itself cleared by the pulse it makes
	// Register writes that land during the pulse are lost
	dmc_soft_reset u_srst (
		.ref_clk    (ref_clk),
		.rst_b      (rst_b),
		.trig_write (trig_write),
		.armed      (arm_seen),
		.engine_rst (eng_rst)
	);

	// Size decode from the five one-hot bits
	// Size is only used at beat time, so changing it while idle is harmless
	dmc_beat_size u_size (
		.size_sel   ({ctrl_r[dmc_pkg::CT_QUADWORD], ctrl_r[dmc_pkg::CT_DOUBLEWORD],
			ctrl_r[dmc_pkg::CT_WORD], ctrl_r[dmc_pkg::CT_HALFWORD],
			ctrl_r[dmc_pkg::CT_BYTE]}),
		.beat_bytes (beat_bytes)
	);

	// Busy covers both request states, with no idle gap between beats
	assign busy    = (state_r != dmc_pkg::DMC_IDLE);
	assign rd_beat = (state_r == dmc_pkg::DMC_READ) && rd_ack;
	assign wr_beat = (state_r == dmc_pkg::DMC_WRITE) && wr_ack;

	// Length never wraps below zero
	always_comb begin
		if (len_r > LEN_W'(beat_bytes)) begin
			len_after = len_r - LEN_W'(beat_bytes);
		end else begin
			len_after = '0;
		end
	end

	// End conditions, each gated by its enable bit
	assign end_rd_pkt = ctrl_r[dmc_pkg::CT_STOP_RD_EOP] && eop_hold_r;
	assign end_wr_pkt = ctrl_r[dmc_pkg::CT_STOP_WR_EOP] && wr_eop;
	assign end_count  = ctrl_r[dmc_pkg::CT_STOP_COUNT] && (len_after == '0);
	// Run gates the end: a transaction aborted by clearing run never reports done,
	// even when its last write lands after the clear
	assign finish     = wr_beat && ctrl_r[dmc_pkg::CT_RUN] &&
		(end_rd_pkt || end_wr_pkt || end_count);

	// Next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			dmc_pkg::DMC_IDLE: begin
				// Waits here until run is set with a length loaded
				if (ctrl_r[dmc_pkg::CT_RUN] && (len_r != '0)) begin
					state_nxt = dmc_pkg::DMC_READ;
				end
			end
			dmc_pkg::DMC_READ: begin
				if (!ctrl_r[dmc_pkg::CT_RUN]) begin
					// Run dropped before this beat was read; earlier beats may have moved: abandon quietly
					state_nxt = dmc_pkg::DMC_IDLE;
				end else if (rd_ack) begin
					// Beat taken; the data now waits for the write side
					state_nxt = dmc_pkg::DMC_WRITE;
				end
			end
			dmc_pkg::DMC_WRITE: begin
				if (finish) begin
					// A stop condition was met on this beat
					state_nxt = dmc_pkg::DMC_IDLE;
				end else if (wr_ack && !ctrl_r[dmc_pkg::CT_RUN]) begin
					// Run dropped: the beat completes, the flag stays clear
					state_nxt = dmc_pkg::DMC_IDLE;
				end else if (wr_ack) begin
					// More to move; back for the next read
					state_nxt = dmc_pkg::DMC_READ;
				end
			end
			default: begin
				state_nxt = dmc_pkg::DMC_IDLE;
			end
		endcase
	end

	// State register; the soft reset acts like a system reset
	// and wins over the next state, so a half-done beat is abandoned
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= dmc_pkg::DMC_IDLE;
		end else if (eng_rst) begin
			state_r <= dmc_pkg::DMC_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Control register; reset bit reads as first write pending
	// Bit 12 is stored but reads back from the sequencer instead
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r <= dmc_pkg::CONTROL_RESET;
		end else if (eng_rst) begin
			ctrl_r <= dmc_pkg::CONTROL_RESET;
		end else if (reg_wr && sel_ctrl) begin
			ctrl_r <= reg_wdata[12:0];
		end
	end

	// Read address: loaded by software, steps unless fixed
	// Wraps at the top of the space; keeping ranges in bounds is up to software
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_addr_r <= '0;
		end else if (eng_rst) begin
			rd_addr_r <= '0;
		end else if (reg_wr && sel_rdaddr) begin
			rd_addr_r <= reg_wdata[ADDR_W-1:0];
		end else if (rd_beat && !ctrl_r[dmc_pkg::CT_FIX_RD]) begin
			rd_addr_r <= rd_addr_r + ADDR_W'(beat_bytes);
		end
	end

	// Write address: loaded by software, steps unless fixed
	// Wraps the same way as the read address
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_addr_r <= '0;
		end else if (eng_rst) begin
			wr_addr_r <= '0;
		end else if (reg_wr && sel_wraddr) begin
			wr_addr_r <= reg_wdata[ADDR_W-1:0];
		end else if (wr_beat && !ctrl_r[dmc_pkg::CT_FIX_WR]) begin
			wr_addr_r <= wr_addr_r + ADDR_W'(beat_bytes);
		end
	end

	// Length counts down per written beat
	// A software load wins over a beat; loading while busy is not supported
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			len_r <= '0;
		end else if (eng_rst) begin
			len_r <= '0;
		end else if (reg_wr && sel_len) begin
			len_r <= reg_wdata[LEN_W-1:0];
		end else if (wr_beat) begin
			len_r <= len_after;
		end
	end

	// Data beat and read eop captured on read acceptance
	// Holding eop beside the data lets the stop act on the matching write
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			data_r     <= '0;
			eop_hold_r <= 1'b0;
		end else if (eng_rst) begin
			data_r     <= '0;
			eop_hold_r <= 1'b0;
		end else if (rd_beat) begin
			data_r     <= rd_data;
			eop_hold_r <= rd_eop;
		end
	end

	// Completion flag; hardware set wins over a status write
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			done_r <= 1'b0;
		end else if (eng_rst) begin
			done_r <= 1'b0;
		end else if (finish) begin
			done_r <= 1'b1;
		end else if (reg_wr && sel_status) begin
			done_r <= 1'b0;
		end
	end

	// Cause flags stay until software clears status
	// Packet causes latch only with a completion; the count flag sets whenever a written beat takes the length to zero
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_pkt_r   <= 1'b0;
			wr_pkt_r   <= 1'b0;
			cnt_zero_r <= 1'b0;
		end else if (eng_rst) begin
			rd_pkt_r   <= 1'b0;
			wr_pkt_r   <= 1'b0;
			cnt_zero_r <= 1'b0;
		end else begin
			// Any status write clears; a new event in that cycle still sets
			if (finish && end_rd_pkt) begin
				rd_pkt_r <= 1'b1;
			end else if (reg_wr && sel_status) begin
				rd_pkt_r <= 1'b0;
			end
			if (finish && end_wr_pkt) begin
				wr_pkt_r <= 1'b1;
			end else if (reg_wr && sel_status) begin
				wr_pkt_r <= 1'b0;
			end
			if (wr_beat && (len_after == '0) && (len_r != '0)) begin
				cnt_zero_r <= 1'b1;
			end else if (reg_wr && sel_status) begin
				cnt_zero_r <= 1'b0;
			end
		end
	end

	// Read data, valid the cycle after the strobe only
	// Cleared between reads so a stale value never looks like an answer
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_r <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				dmc_pkg::REG_STATUS_IDX: begin
					rdata_r <= {27'h0, cnt_zero_r, wr_pkt_r, rd_pkt_r, busy, done_r};
				end
				dmc_pkg::REG_RD_ADDR_IDX: begin
					rdata_r <= 32'(rd_addr_r);
				end
				dmc_pkg::REG_WR_ADDR_IDX: begin
					rdata_r <= 32'(wr_addr_r);
				end
				dmc_pkg::REG_LENGTH_IDX: begin
					rdata_r <= 32'(len_r);
				end
				dmc_pkg::REG_CONTROL_IDX: begin
					// Reset bit shows the armed sequencer, then drops back
					rdata_r <= {19'h0, arm_seen, ctrl_r[11:0]};
				end
				default: begin
					rdata_r <= 32'h0000_0000;
				end
			endcase
		end else begin
			rdata_r <= 32'h0000_0000;
		end
	end

	// Requests decode the state register, so they drop on the edge that ends a beat
	assign reg_rdata = rdata_r;
	assign rd_req    = (state_r == dmc_pkg::DMC_READ);
	assign wr_req    = (state_r == dmc_pkg::DMC_WRITE);
	assign rd_addr   = rd_addr_r;
	assign wr_addr   = wr_addr_r;
	assign wr_data   = data_r;
	// Interrupt is a pure level of flag and enable
	assign irq       = done_r && ctrl_r[dmc_pkg::CT_IRQ_EN];
endmodule

// [verification/dmc_engine_props.sv]
`timescale 1ns/100ps
// Port-level checks on the engine
module dmc_engine_props #(
	parameter int ADDR_W = 32
) (
	input wire logic              ref_clk,
	input wire logic              rst_b,
	input wire logic [2:0]        reg_addr,
	input wire logic [31:0]       reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [31:0]       reg_rdata,
	input wire logic              rd_req,
	input wire logic [ADDR_W-1:0] rd_addr,
	input wire logic              rd_ack,
	input wire logic              wr_req,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic              wr_ack,
	input wire logic              irq
);
	logic irq_en_r; // Last interrupt enable written
	logic run_en_r; // Last run bit written
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Shadows of enable and run; a soft reset clears the real ones, so none is issued while running
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_en_r <= 1'b0;
			run_en_r <= 1'b0;
		end else if (reg_wr && reg_addr == dmc_pkg::REG_CONTROL_IDX) begin
			irq_en_r <= reg_wdata[dmc_pkg::CT_IRQ_EN];
			run_en_r <= reg_wdata[dmc_pkg::CT_RUN];
		end
	end
	AST_IRQ_MASK: assert property (irq |-> irq_en_r)
		else $error("irq while masked");
	AST_IRQ_ACK: assert property (reg_wr && reg_addr == dmc_pkg::REG_STATUS_IDX && !wr_req |=> !irq)
		else $error("irq survives status write");
	AST_RDATA_QUIET: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data without read");
	AST_BUSY: assert property (reg_rd && reg_addr == dmc_pkg::REG_STATUS_IDX
		|=> reg_rdata[dmc_pkg::ST_BUSY] == ($past(rd_req) | $past(wr_req))) else $error("busy wrong");
	AST_RD_HOLD: assert property (rd_req && !rd_ack && !reg_wr && run_en_r |=> rd_req && $stable(rd_addr))
		else $error("read request moved");
	AST_WR_HOLD: assert property (wr_req && !wr_ack && !reg_wr |=> wr_req && $stable(wr_addr))
		else $error("write request moved");
	AST_ALT: assert property (rd_req && rd_ack && !reg_wr && run_en_r |=> wr_req && !rd_req)
		else $error("no write after read");
	AST_ONE_BEAT: assert property (wr_req && wr_ack |=> !wr_req)
		else $error("write beat repeated");
endmodule

// [verification/dmc_mem_agent.sv]
`timescale 1ns/100ps
// Source and sink memories; each beat is acked wait_cyc + 1 cycles after its request rises
module dmc_mem_agent #(
	parameter int ADDR_W = 32,
	parameter int DATA_W = 128
) (
	input wire logic              ref_clk,
	input wire logic              rst_b,
	input wire logic [1:0]        wait_cyc,
	input wire logic              rd_eop_on,
	input wire logic              wr_eop_on,
	input wire logic              rd_req,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic                  rd_ack,
	output logic     [DATA_W-1:0] rd_data,
	output logic                  rd_eop,
	input wire logic              wr_req,
	output logic                  wr_ack,
	output logic                  wr_eop
);
	logic [1:0] rd_cnt_r; // Read wait so far
	logic [1:0] wr_cnt_r; // Write wait so far
	logic       rd_go;    // Read beat answered next edge
	logic       wr_go;    // Write beat answered next edge
	assign rd_go = rd_req && !rd_ack && rd_cnt_r == wait_cyc;
	assign wr_go = wr_req && !wr_ack && wr_cnt_r == wait_cyc;
	// Data is only meaningful with ack; it toggles otherwise so stale use shows
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_ack   <= 1'b0;
			rd_eop   <= 1'b0;
			rd_data  <= '0;
			rd_cnt_r <= 2'h0;
		end else begin
			rd_ack   <= rd_go;
			rd_eop   <= rd_go && rd_eop_on;
			rd_data  <= rd_go ? {(DATA_W / ADDR_W){rd_addr}} : ~rd_data;
			rd_cnt_r <= (rd_req && !rd_ack && !rd_go) ? rd_cnt_r + 2'h1 : 2'h0;
		end
	end
	// Write side accepts after the same wait
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ack   <= 1'b0;
			wr_eop   <= 1'b0;
			wr_cnt_r <= 2'h0;
		end else begin
			wr_ack   <= wr_go;
			wr_eop   <= wr_go && wr_eop_on;
			wr_cnt_r <= (wr_req && !wr_ack && !wr_go) ? wr_cnt_r + 2'h1 : 2'h0;
		end
	end
endmodule

// [verification/dmc_engine_tb_top.sv]
`timescale 1ns/100ps
// Register-driven scenarios against the engine and its memories
module dmc_engine_tb_top;
	logic         ref_clk;
	logic         rst_b;
	logic [2:0]   reg_addr;
	logic [31:0]  reg_wdata;
	logic         reg_wr, reg_rd, rd_req, rd_ack, rd_eop, wr_req, wr_ack, wr_eop, irq;
	logic [31:0]  reg_rdata, rd_addr, wr_addr, last_rd, last_wr, last_wd;
	logic [127:0] rd_data, wr_data;
	logic [1:0]   wait_cyc;
	logic         rd_eop_on, wr_eop_on;
	int           n_fail, samples_checked, n_wr, cyc;
	int           sz_pos[5] = '{0, 1, 2, 10, 11};
	logic [31:0]  sz_extra[5] = '{32'h10, 32'h110, 32'h210, 32'h0, 32'h310};
	dmc_engine dmc_engine_inst (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rd_req(rd_req), .rd_addr(rd_addr),
		.rd_ack(rd_ack), .rd_data(rd_data), .rd_eop(rd_eop), .wr_req(wr_req), .wr_addr(wr_addr),
		.wr_data(wr_data), .wr_ack(wr_ack), .wr_eop(wr_eop), .irq(irq));
	dmc_mem_agent dmc_mem_agent_inst (.ref_clk(ref_clk), .rst_b(rst_b), .wait_cyc(wait_cyc),
		.rd_eop_on(rd_eop_on), .wr_eop_on(wr_eop_on), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack),
		.rd_data(rd_data), .rd_eop(rd_eop), .wr_req(wr_req), .wr_ack(wr_ack), .wr_eop(wr_eop));
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Beat log, plus a hang guard well above the longest run
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (rd_req && rd_ack) last_rd <= rd_addr;
		if (wr_req && wr_ack) begin
			n_wr    <= n_wr + 1;
			last_wr <= wr_addr;
			last_wd <= wr_data[31:0];
		end
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	// One-cycle strobes with an idle cycle after, so no strobe is set twice in a step
	task automatic wreg(input logic [2:0] i, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= i;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask
	task automatic rchk(input string n, input logic [2:0] i, input logic [31:0] e);
		@(posedge ref_clk);
		reg_addr <= i;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		#1 chk(n, e, reg_rdata);
	endtask
	// Run is dropped first: left set, the length write would start the engine early
	task automatic start(input logic [31:0] ctl, input logic [31:0] len);
		wreg(dmc_pkg::REG_CONTROL_IDX, 32'h0);
		wreg(dmc_pkg::REG_RD_ADDR_IDX, 32'h100);
		wreg(dmc_pkg::REG_WR_ADDR_IDX, 32'h200);
		wreg(dmc_pkg::REG_LENGTH_IDX, len);
		wreg(dmc_pkg::REG_CONTROL_IDX, ctl);
	endtask
	// Busy is held through read and write states, so idle means both requests low
	task automatic wait_idle();
		repeat (2) @(posedge ref_clk);
		for (int k = 0; k < 300; k++) begin
			#1;
			if (!rd_req && !wr_req) break;
			@(posedge ref_clk);
		end
	endtask
	task automatic t_reset_vals();
		rchk("status", dmc_pkg::REG_STATUS_IDX, 32'h0);
		rchk("control", dmc_pkg::REG_CONTROL_IDX, 32'h0);
		rchk("unmapped", 3'h5, 32'h0);
	endtask
	// Three beats with run, count stop and the given enable and fixed-address bits
	task automatic t_xfer(input int p, input logic [31:0] x, input logic [1:0] w);
		logic [31:0] b;
		int          r0;
		b = 32'h1 << (p > 2 ? p - 7 : p);
		@(posedge ref_clk);
		wait_cyc <= w;
		r0 = n_wr;
		start((32'h1 << p) | 32'h88 | x, 3 * b);
		wait_idle();
		chk("beats", 32'h3, 32'(n_wr - r0));
		chk("rd addr", 32'h100 + (x[8] ? 32'h0 : 2 * b), last_rd);
		chk("wr addr", 32'h200 + (x[9] ? 32'h0 : 2 * b), last_wr);
		// The agent answers each read with its address, so the last write carries it
		chk("wr data", 32'h100 + (x[8] ? 32'h0 : 2 * b), last_wd);
		chk("irq", {31'h0, x[4]}, {31'h0, irq});
		rchk("status", dmc_pkg::REG_STATUS_IDX, 32'h11);
		rchk("length", dmc_pkg::REG_LENGTH_IDX, 32'h0);
		rchk("control", dmc_pkg::REG_CONTROL_IDX, (32'h1 << p) | 32'h88 | x);
		wreg(dmc_pkg::REG_STATUS_IDX, 32'h0);
		rchk("status ack", dmc_pkg::REG_STATUS_IDX, 32'h0);
		chk("irq ack", 32'h0, {31'h0, irq});
	endtask
	task automatic t_rd_eop();
		@(posedge ref_clk);
		rd_eop_on <= 1'b1;
		// One beat, no count stop; run stays set, so only the read packet end stops it
		start(32'h2c, 32'h4);
		wait_idle();
		@(posedge ref_clk);
		rd_eop_on <= 1'b0;
		rchk("status", dmc_pkg::REG_STATUS_IDX, 32'h15);
		rchk("length", dmc_pkg::REG_LENGTH_IDX, 32'h0);
		wreg(dmc_pkg::REG_STATUS_IDX, 32'h0);
	endtask
	// No count stop: length runs out after two beats, packet end stops the third
	task automatic t_wr_eop();
		int r0;
		r0 = n_wr;
		start(32'h4c, 32'h8);
		for (int k = 0; k < 200 && n_wr - r0 < 2; k++) @(posedge ref_clk);
		wr_eop_on <= 1'b1;
		wait_idle();
		@(posedge ref_clk);
		wr_eop_on <= 1'b0;
		chk("beats", 32'h3, 32'(n_wr - r0));
		rchk("status", dmc_pkg::REG_STATUS_IDX, 32'h19);
		rchk("length", dmc_pkg::REG_LENGTH_IDX, 32'h0);
		wreg(dmc_pkg::REG_STATUS_IDX, 32'h0);
	endtask
	task automatic t_run_clear();
		@(posedge ref_clk);
		wait_cyc <= 2'h3;
		start(32'h8c, 32'h40);
		wreg(dmc_pkg::REG_CONTROL_IDX, 32'h84);
		wait_idle();
		rchk("status", dmc_pkg::REG_STATUS_IDX, 32'h0);
		repeat (3) @(posedge ref_clk);
		chk("rd_req", 32'h0, {31'h0, rd_req});
		// Second pass drops run while the only write beat is still waiting
		start(32'h8c, 32'h4);
		for (int k = 0; k < 100 && !wr_req; k++) @(posedge ref_clk);
		wreg(dmc_pkg::REG_CONTROL_IDX, 32'h84);
		wait_idle();
		rchk("status late", dmc_pkg::REG_STATUS_IDX, 32'h10);
		wreg(dmc_pkg::REG_STATUS_IDX, 32'h0);
	endtask
	task automatic t_soft_reset();
		wreg(dmc_pkg::REG_LENGTH_IDX, 32'h40);
		wreg(dmc_pkg::REG_CONTROL_IDX, 32'h1090);
		rchk("control", dmc_pkg::REG_CONTROL_IDX, 32'h1090);
		wreg(dmc_pkg::REG_CONTROL_IDX, 32'h1090);
		repeat (2) @(posedge ref_clk);
		rchk("control", dmc_pkg::REG_CONTROL_IDX, 32'h0);
		rchk("length", dmc_pkg::REG_LENGTH_IDX, 32'h0);
		rchk("rd addr", dmc_pkg::REG_RD_ADDR_IDX, 32'h0);
	endtask
	initial begin
		rst_b     = 1'b0;
		reg_addr  = 3'h0;
		reg_wdata = 32'h0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		wait_cyc  = 2'h0;
		rd_eop_on = 1'b0;
		wr_eop_on = 1'b0;
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_reset_vals();
		for (int i = 0; i < 5; i++) t_xfer(sz_pos[i], sz_extra[i], 2'(i));
		t_rd_eop();
		t_wr_eop();
		t_run_clear();
		t_soft_reset();
		close_out();
	end
endmodule
bind dmc_engine dmc_engine_props #(.ADDR_W(ADDR_W)) dmc_engine_props_inst (.ref_clk(ref_clk), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack), .wr_req(wr_req), .wr_addr(wr_addr),
	.wr_ack(wr_ack), .irq(irq));
